// ---- rtl/ssp_spi_port.v ----
// ssp_spi_port.v: synchronous serial port in spi mode with axi4-lite register access
// assumes an external spi peer on sck/sdi/sdo/ss pins, asynchronous to aclk
//
// Operation
// RULE1 - data-or-address flag reports last byte kind
// RULE2 - stop flag set on stop, zero after reset
// RULE3 - disabling the port clears stop flag
// RULE4 - start condition clears stop flag
// RULE5 - disable or stop clears start flag
// RULE6 - unimplemented bits read as zero
// RULE7 - buffer undefined on power-on, kept otherwise
// RULE8 - eight bits out and in per transfer
// RULE9 - pins serve the port only while enabled
// RULE10 - software disables, rewrites control, then enables
// RULE11 - sample phase and edge select timing; master modes ignore the edge select bit, only slave modes use it
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_spi_port (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        por_resetn,
  // axi4-lite write
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial pins
  input  wire        sck_i,
  output reg         sck_o,
  output wire        sck_oe,
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  output wire        serial_out_oe,
  input  wire        ss_n,
  // bus condition events from the shared bus detector
  input  wire        start_seen,
  input  wire        stop_seen,
  // interrupt
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg  [1:0] sck_sync_reg;
  reg  [1:0] sdi_sync_reg;
  reg  [1:0] ss_sync_reg;
  reg        sck_prev_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      ss_sync_reg  <= 2'h3;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], sck_i};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_in_pin};
      ss_sync_reg  <= {ss_sync_reg[0], ss_n};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end
  wire sck_s = sck_sync_reg[1];
  wire sdi_s = sdi_sync_reg[1];
  wire ss_s  = ss_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0] ctl_reg;
  reg  [1:0] stat_cfg_reg;
  reg        da_reg;
  reg        stop_reg;
  reg        start_reg;
  reg        bf_reg;
  reg  [7:0] buf_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] port_a_direction_reg;
  reg  [7:0] port_c_direction_reg;
  reg  [7:0] pir_reg;
  reg  [7:0] pie_reg;
  reg  [7:0] intctl_reg;
  reg  [2:0] evt_reg;
  reg  [2:0] evtmask_reg;

  wire       en      = ctl_reg[`SSP_CTL_EN];
  wire       clock_idle_polarity     = ctl_reg[`SSP_CTL_CKP];
  wire [3:0] mode    = ctl_reg[3:0];
  wire       master  = (mode < 4'h4);
  wire       slave   = (mode == 4'h4) || (mode == 4'h5);
  wire       ss_used = (mode == 4'h4);
  wire       sample_phase_bit     = stat_cfg_reg[1];
  wire       cke     = stat_cfg_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  reg  [7:0] awaddr_reg;
  reg        aw_have_reg;
  reg  [7:0] wdata_reg;
  reg        w_have_reg;
  wire       wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire       rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0] rd_idx  = s_axi_araddr[9:2];
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `SSP_IDX_INTCTL, `SSP_IDX_PIRF, `SSP_IDX_BUF, `SSP_IDX_CTL,
        `SSP_IDX_PORT_A_DIRECTION, `SSP_IDX_PORT_C_DIRECTION, `SSP_IDX_PIEN, `SSP_IDX_STAT,
        `SSP_IDX_EVT, `SSP_IDX_EVTMASK, `SSP_IDX_BUSCOND: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  wire       wr_ctl   = wr_fire && awaddr_reg == `SSP_IDX_CTL;
  wire       wr_stat  = wr_fire && awaddr_reg == `SSP_IDX_STAT;
  wire       wr_buf   = wr_fire && awaddr_reg == `SSP_IDX_BUF;
  wire       rd_buf   = rd_fire && rd_idx == `SSP_IDX_BUF;
  wire       wr_evt   = wr_fire && awaddr_reg == `SSP_IDX_EVT;
  wire       wr_pir   = wr_fire && awaddr_reg == `SSP_IDX_PIRF;

  reg  [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (rd_idx)
      `SSP_IDX_INTCTL:  rd_val = intctl_reg;
      `SSP_IDX_PIRF:    rd_val = pir_reg & `SSP_PIR_MASK; // RULE6
      `SSP_IDX_PIEN:    rd_val = pie_reg & `SSP_PIR_MASK; // RULE6
      `SSP_IDX_BUF:     rd_val = buf_reg;
      `SSP_IDX_CTL:     rd_val = ctl_reg;
      `SSP_IDX_PORT_A_DIRECTION:   rd_val = port_a_direction_reg & `SSP_PORT_A_DIRECTION_MASK; // RULE6
      `SSP_IDX_PORT_C_DIRECTION:   rd_val = port_c_direction_reg;
      `SSP_IDX_STAT:    rd_val = {stat_cfg_reg, da_reg, stop_reg, start_reg, 2'h0, bf_reg}; // RULE6
      `SSP_IDX_EVT:     rd_val = {5'h00, evt_reg};
      `SSP_IDX_EVTMASK: rd_val = {5'h00, evtmask_reg};
      `SSP_IDX_BUSCOND: rd_val = {6'h00, stop_reg, start_reg};
      default:          rd_val = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_val};
        s_axi_rresp  <= mapped(rd_idx) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock divider: fosc/4, /16, /64 in core cycles
  reg  [7:0] div_cnt_reg;
  wire [7:0] div_lim = (mode == 4'h0) ? `SSP_DIV_BASE :
                       (mode == 4'h1) ? (`SSP_DIV_BASE << 2) : (`SSP_DIV_BASE << 4);
  wire       half_tick = (div_cnt_reg == ((div_lim >> 1) - 8'd1));

  ////////////////////////////////////////////////////////////////////////////
  // shift engine
  localparam ST_IDLE = 2'h0;
  localparam ST_LEAD = 2'h1;
  localparam ST_TRAIL = 2'h2;
  reg  [1:0] state_reg;
  reg  [3:0] bit_cnt_reg;
  reg        sdi_hold_reg;
  reg  [1:0] lead_dly_reg;
  wire       sck_rise  = sck_s && !sck_prev_reg;
  wire       sck_fall  = !sck_s && sck_prev_reg;
  // transmit edge: rising when edge select and idle polarity differ
  wire       tx_on_rise = cke ^ clock_idle_polarity; // RULE11
  wire       slv_tx    = tx_on_rise ? sck_rise : sck_fall; // RULE11
  wire       slv_rx    = tx_on_rise ? sck_fall : sck_rise; // RULE11
  wire       slv_ok    = slave && (!ss_used || !ss_s);
  wire       lead_tick = en && master && state_reg == ST_LEAD && half_tick;
  // pin value at the leading edge reaches sdi_s two cycles later
  wire       mid_bit   = lead_dly_reg[1] ? sdi_s : sdi_hold_reg; // RULE11
  wire       rx_bit    = sample_phase_bit ? sdi_s : mid_bit; // RULE11

  always @(posedge aclk) begin
    if (!aresetn) begin
      lead_dly_reg <= 2'h0;
    end else begin
      lead_dly_reg <= {lead_dly_reg[0], lead_tick};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      div_cnt_reg    <= 8'h00;
      sck_o          <= 1'b0;
      serial_out_pin <= 1'b0;
      shift_reg      <= 8'h00;
      sdi_hold_reg   <= 1'b0;
    end else if (!en) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      sck_o       <= clock_idle_polarity;
    end else if (master) begin
      if (state_reg == ST_IDLE) begin
        sck_o <= clock_idle_polarity;
        if (wr_buf) begin
          shift_reg      <= wdata_reg;
          serial_out_pin <= wdata_reg[7];
          bit_cnt_reg    <= 4'h0;
          div_cnt_reg    <= 8'h00;
          state_reg      <= ST_LEAD;
        end
      end else begin
        div_cnt_reg <= half_tick ? 8'h00 : div_cnt_reg + 8'h01;
        // middle sampling: pin as it stood at the leading edge
        if (lead_dly_reg[1] && !sample_phase_bit) sdi_hold_reg <= sdi_s; // RULE11
        if (half_tick) begin
          sck_o <= ~sck_o;
          if (state_reg == ST_LEAD) begin
            state_reg <= ST_TRAIL;
          end else begin
            // end sampling at second edge; shift eight bits
            shift_reg   <= {shift_reg[6:0], rx_bit}; // RULE8
            serial_out_pin <= shift_reg[6];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            state_reg   <= (bit_cnt_reg == 4'h7) ? ST_IDLE : ST_LEAD; // RULE8
          end
        end
      end
    end else if (slv_ok) begin
      if (wr_buf) begin
        shift_reg      <= wdata_reg;
        serial_out_pin <= wdata_reg[7];
        bit_cnt_reg    <= 4'h0;
      end else if (slv_rx) begin
        shift_reg   <= {shift_reg[6:0], sdi_s}; // RULE8
        bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h0 : bit_cnt_reg + 4'h1;
      end else if (slv_tx) begin
        serial_out_pin <= shift_reg[7];
      end
    end
  end

  wire byte_done = en && ((master && state_reg == ST_TRAIL && half_tick && bit_cnt_reg == 4'h7) ||
                          (!master && slv_ok && !wr_buf && slv_rx && bit_cnt_reg == 4'h7));

  // pins serve the port only while enabled and direction bits agree
  assign sck_oe        = en && master && !port_c_direction_reg[3]; // RULE9
  assign serial_out_oe = en && !port_c_direction_reg[5] && (master || !ss_used || !ss_s); // RULE9

  ////////////////////////////////////////////////////////////////////////////
  // buffer, kept across ordinary resets, cleared only at power-on
  always @(posedge aclk) begin
    if (!por_resetn) begin
      buf_reg <= 8'h00; // RULE7
    end else if (byte_done) begin
      buf_reg <= {shift_reg[6:0], master ? rx_bit : sdi_s};
    end else if (wr_buf) begin
      buf_reg <= wdata_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, status and interrupt registers
  wire wcol_evt = wr_buf && en && master && state_reg != ST_IDLE;
  wire ovf_evt  = byte_done && bf_reg && !master;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg      <= `SSP_RST_CTL;
      stat_cfg_reg <= 2'h0;
      da_reg       <= 1'b0;
      stop_reg     <= 1'b0;
      start_reg    <= 1'b0;
      bf_reg       <= 1'b0;
      port_a_direction_reg    <= `SSP_RST_PORT_A_DIRECTION;
      port_c_direction_reg    <= `SSP_RST_PORT_C_DIRECTION;
      pir_reg      <= `SSP_RST_PIR;
      pie_reg      <= 8'h00;
      intctl_reg   <= `SSP_RST_INTCTL;
      evt_reg      <= 3'h0;
      evtmask_reg  <= 3'h0;
    end else begin
      if (wr_ctl) ctl_reg <= wdata_reg;
      if (wcol_evt) ctl_reg[`SSP_CTL_WCOL] <= 1'b1;
      if (ovf_evt) ctl_reg[`SSP_CTL_OVF] <= 1'b1;
      if (wr_stat) stat_cfg_reg <= wdata_reg[7:6];
      if (slave) stat_cfg_reg[1] <= 1'b0; // RULE11
      // every spi byte is data, never address
      if (byte_done) da_reg <= 1'b1; // RULE1
      if (!en) begin
        stop_reg  <= 1'b0; // RULE3
        start_reg <= 1'b0; // RULE5
      end else if (stop_seen) begin
        stop_reg  <= 1'b1; // RULE2
        start_reg <= 1'b0; // RULE5
      end else if (start_seen) begin
        start_reg <= 1'b1;
        stop_reg  <= 1'b0; // RULE4
      end
      if (byte_done) bf_reg <= 1'b1;
      else if (rd_buf) bf_reg <= 1'b0;
      if (wr_fire && awaddr_reg == `SSP_IDX_PORT_A_DIRECTION) port_a_direction_reg <= wdata_reg & `SSP_PORT_A_DIRECTION_MASK;
      if (wr_fire && awaddr_reg == `SSP_IDX_PORT_C_DIRECTION) port_c_direction_reg <= wdata_reg;
      if (wr_fire && awaddr_reg == `SSP_IDX_PIEN) pie_reg <= wdata_reg & `SSP_PIR_MASK;
      if (wr_fire && awaddr_reg == `SSP_IDX_INTCTL) intctl_reg <= wdata_reg;
      if (wr_fire && awaddr_reg == `SSP_IDX_EVTMASK) evtmask_reg <= wdata_reg[2:0];
      // set wins over clear
      if (wr_pir) pir_reg <= wdata_reg & `SSP_PIR_MASK;
      if (byte_done) pir_reg[`SSP_PIR_SERIAL] <= 1'b1;
      evt_reg <= (evt_reg & ~(wr_evt ? wdata_reg[2:0] : 3'h0)) |
                 {wcol_evt, ovf_evt, byte_done};
    end
  end

  assign irq = |(evt_reg & evtmask_reg) ||
               (pir_reg[`SSP_PIR_SERIAL] && pie_reg[`SSP_PIR_SERIAL]);

endmodule

// ---- rtl/ssp_defines.vh ----
// ssp_defines.vh: register offsets, field positions, reset values and timing counts
// assumes inclusion by ssp_spi_port.v only
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// register indexes; the byte address is four times the index
`define SSP_IDX_INTCTL     8'h0b
`define SSP_IDX_PIRF       8'h0c
`define SSP_IDX_BUF        8'h13
`define SSP_IDX_CTL        8'h14
`define SSP_IDX_PORT_A_DIRECTION      8'h85
`define SSP_IDX_PORT_C_DIRECTION      8'h87
`define SSP_IDX_PIEN       8'h8c
`define SSP_IDX_STAT       8'h94
`define SSP_IDX_EVT        8'h98
`define SSP_IDX_EVTMASK    8'h99
`define SSP_IDX_BUSCOND    8'h9a

// control register fields
`define SSP_CTL_WCOL       7
`define SSP_CTL_OVF        6
`define SSP_CTL_EN         5
`define SSP_CTL_CKP        4

// status register fields
`define SSP_ST_SMP         7
`define SSP_ST_CKE         6
`define SSP_ST_DA          5
`define SSP_ST_STOP        4
`define SSP_ST_START       3
`define SSP_ST_BF          0

// interrupt flag / enable positions
`define SSP_PIR_SERIAL     3
`define SSP_PIR_MASK       8'h4f

// reset values
`define SSP_RST_CTL        8'h00
`define SSP_RST_STAT       8'h00
`define SSP_RST_PORT_A_DIRECTION      8'h3f
`define SSP_RST_PORT_C_DIRECTION      8'hff
`define SSP_RST_PIR        8'h00
`define SSP_RST_INTCTL     8'h00
`define SSP_PORT_A_DIRECTION_MASK     8'h3f

// master clock divider base: core cycles per instruction clock, the fosc/4 sck period
`define SSP_DIV_BASE       8'd4

`endif

// ---- bench/ssp_spi_port_chk.sv ----
// ssp_spi_port_chk.sv: port-level assertions for the serial port block
// assumes a single aclk domain with synchronous active-low aresetn
`timescale 1ns/1ps
module ssp_spi_port_chk (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // axi4-lite
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  // pins and interrupt
  input wire        sck_oe,
  input wire        serial_out_oe,
  input wire        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  b_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  r_err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  r_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits set");
  pins_idle_a: assert property ($rose(aresetn) |-> !sck_oe && !serial_out_oe && !irq)
    else $error("pins driven after reset");
endmodule

bind ssp_spi_port ssp_spi_port_chk ssp_spi_port_chk_inst (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rresp, .s_axi_rdata, .sck_oe, .serial_out_oe, .irq);

// ---- bench/ssp_spi_peer.sv ----
// ssp_spi_peer.sv: behavioural spi peer, one byte shift register on whichever clock runs
// assumes sck idles low; data change on falling edges, sampled on rising
`timescale 1ns/1ps
module ssp_spi_peer (
  // link
  input  wire        sck,
  input  wire        mosi,
  output logic       miso,
  // bench side
  input  wire        load,
  input  wire  [7:0] tx,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h0;
  int         n  = 8;

  initial miso = 1'h0;
  initial rx = 8'h0;
  always @(posedge load) begin
    sh = tx;
    n = 0;
    miso = tx[7];
  end
  always @(posedge sck) begin
    rx = {rx[6:0], mosi};
  end
  // after eight bits the line is released: show the inverse, not a stale bit
  always @(negedge sck) begin
    sh = {sh[6:0], 1'h0};
    n = n + 1;
    miso = (n < 8) ? sh[7] : ~miso;
  end
endmodule

// ---- bench/ssp_spi_port_tb.sv ----
// ssp_spi_port_tb.sv: self-checking bench for the serial port block
// assumes the spi peer model and the bound checker are compiled alongside
`timescale 1ns/1ps
module ssp_spi_port_tb;
  logic        aclk = 0, aresetn = 0, por_resetn = 0, sck_i = 0, ss_n = 1;
  logic        start_seen = 0, stop_seen = 0, pload = 0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         sck_o, sck_oe, serial_in_pin, serial_out_pin, serial_out_oe, irq;
  logic [7:0]  ptx = 8'h0, d;
  wire  [7:0]  prx;
  logic [1:0]  rsp;
  int          fails = 0, total_checks = 0, cyc = 0;

  always #2 aclk = ~aclk;
  ssp_spi_port ssp_spi_port_inst (.*);
  ssp_spi_peer ssp_spi_peer_inst (.sck(sck_oe ? sck_o : sck_i), .mosi(serial_out_pin),
    .miso(serial_in_pin), .load(pload), .tx(ptx), .rx(prx));

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      t++;
    end while (!s_axi_bvalid && t < 100);
    if (!s_axi_bvalid) fails++;
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      t++;
    end while (!s_axi_rvalid && t < 100);
    if (!s_axi_rvalid) fails++;
    d = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    rd(i);
    chk(d & m, e);
  endtask
  task automatic pulse(input logic stop);
    @(posedge aclk);
    if (stop) stop_seen <= 1'h1;
    else start_seen <= 1'h1;
    @(posedge aclk);
    stop_seen <= 1'h0;
    start_seen <= 1'h0;
  endtask
  // one byte each way; slave modes get an 80 ns link clock from the bench
  task automatic xfer(input logic [7:0] ctl, tris, tx, wb, st);
    int n;
    wr(8'h14, 8'h00);
    wr(8'h87, tris);
    wr(8'h94, st);
    wr(8'h98, 8'h07);
    ptx <= tx;
    pload <= 1'h1;
    @(posedge aclk);
    pload <= 1'h0;
    wr(8'h14, ctl);
    wr(8'h13, wb);
    chk({sck_oe, serial_out_oe}, {~ctl[2], 1'h1});
    if (ctl[2]) repeat (16) begin
      repeat (10) @(posedge aclk);
      sck_i <= ~sck_i;
    end
    n = 0;
    d = 8'h0;
    while (!d[0] && n < 60) begin
      rd(8'h98);
      n++;
    end
    chk(prx, wb);
    rc(8'h13, 8'hff, tx);
    rc(8'h94, 8'h20, 8'h20);
    $display("transfer test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ix [6] = '{8'h14, 8'h94, 8'h85, 8'h87, 8'h8c, 8'h0c};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h3f, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rc(ix[i], 8'hff, rv[i]);
    end
    $display("reset values test done");
  endtask
  task automatic t_cond;
    wr(8'h14, 8'h20);
    pulse(1'h1);
    rc(8'h94, 8'h18, 8'h10);
    pulse(1'h0);
    rc(8'h94, 8'h18, 8'h08);
    pulse(1'h1);
    rc(8'h94, 8'h18, 8'h10);
    wr(8'h14, 8'h00);
    rc(8'h94, 8'h18, 8'h00);
    wr(8'h14, 8'h20);
    pulse(1'h0);
    wr(8'h14, 8'h00);
    rc(8'h94, 8'h18, 8'h00);
    $display("bus condition test done");
  endtask
  task automatic t_irq;
    logic a;
    wr(8'h99, 8'hff);
    @(posedge aclk);
    a = irq;
    wr(8'h99, 8'h00);
    @(posedge aclk);
    chk(a ^ irq, 1'h1);
    wr(8'h98, 8'h07);
    @(posedge aclk);
    chk(irq, 1'h0);
    wr(8'h99, 8'hff);
    @(posedge aclk);
    chk(irq, 1'h0);
    $display("interrupt test done");
  endtask
  task automatic t_refuse;
    logic [7:0] ix [3] = '{8'h0c, 8'h8c, 8'h85};
    logic [7:0] mk [3] = '{8'hb0, 8'hb0, 8'hc0};
    rc(8'h40, 8'hff, 8'h00);
    chk(rsp, 2'h2);
    wr(8'h40, 8'h55);
    chk(rsp, 2'h2);
    for (int i = 0; i < 3; i++) begin
      wr(ix[i], 8'hff);
      rc(ix[i], mk[i], 8'h00);
      wr(ix[i], 8'h00);
    end
    $display("refusal test done");
  endtask
  task automatic t_keep;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h13, 8'hff, 8'hc3);
    aresetn <= 1'h0;
    por_resetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    por_resetn <= 1'h1;
    rc(8'h13, 8'hff, 8'h00);
    rc(8'h94, 8'hff, 8'h00);
    $display("buffer keep test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      summarize;
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    por_resetn <= 1'h1;
    t_reset;
    t_cond;
    xfer(8'h20, 8'hd7, 8'h3c, 8'ha5, 8'h00);
    t_irq;
    xfer(8'h21, 8'hd7, 8'h96, 8'h69, 8'h80);
    xfer(8'h25, 8'hdf, 8'hc3, 8'h5a, 8'h00);
    t_refuse;
    t_keep;
    summarize;
  end
endmodule
